/* shared/tsc_pkg.sv */
// package for the timer slave/trigger controller
// assumes a single 100 MHz kernel clock; the filter clock arrives as a level whose rising edges are detected in the kernel domain
package tsc_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] OFF_SLAVE_MODE_CONTROL = 4'h8;
	localparam logic [3:0] OFF_SLAVE_STATUS = 4'hC;
	localparam logic [31:0] SMC_RESET = 32'h00000000;
	localparam logic [31:0] SMC_WRITE_MASK = 32'h0031FFF7;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int POS_POL = 15;
	localparam int POS_ECE = 14;
	localparam int POS_PSC_HI = 13;
	localparam int POS_PSC_LO = 12;
	localparam int POS_FLT_HI = 11;
	localparam int POS_FLT_LO = 8;
	localparam int POS_MSM = 7;
	localparam int POS_TSL_HI = 6;
	localparam int POS_TSL_LO = 4;
	localparam int POS_TSU_HI = 21;
	localparam int POS_TSU_LO = 20;
	localparam int POS_SMS3 = 16;
	localparam int POS_SMSL_HI = 2;
	localparam int POS_SMSL_LO = 0;

	// ----------------------------------------
	// status bits
	// ----------------------------------------
	localparam int POS_TRIG_FLAG = 0;
	localparam int POS_RUN = 1;
	localparam int POS_FILT_OUT = 2;
	localparam int POS_TRIG_IN = 3;

	// ----------------------------------------
	// codes
	// ----------------------------------------
	localparam logic [4:0] TS_INTERNAL_TRIGGER_ZERO = 5'h00;
	localparam logic [4:0] TS_CH1_EDGE = 5'h04;
	localparam logic [4:0] TS_CH1_FILT = 5'h05;
	localparam logic [4:0] TS_CH2_FILT = 5'h06;
	localparam logic [4:0] TS_EXT_FILT = 5'h07;

	localparam logic [3:0] SM_OFF = 4'h0;
	localparam logic [3:0] SM_ENC1 = 4'h1;
	localparam logic [3:0] SM_ENC2 = 4'h2;
	localparam logic [3:0] SM_ENC3 = 4'h3;
	localparam logic [3:0] SM_RESET = 4'h4;
	localparam logic [3:0] SM_GATED = 4'h5;
	localparam logic [3:0] SM_TRIGGER = 4'h6;
	localparam logic [3:0] SM_EXTCLK1 = 4'h7;
	localparam logic [3:0] SM_COMBINED = 4'h8;

	localparam logic [3:0] FLT_NONE = 4'h0;
	localparam logic [3:0] FLT_KCLK_MAX = 4'h3;

	// ----------------------------------------
	// counter actions toward the counter core
	// ----------------------------------------
	typedef struct packed {
		logic countTick;
		logic countDown;
		logic counterReinit;
		logic updateEvent;
		logic counterStart;
	} tsc_cnt_ctrl_t;

endpackage

/* design/tsc_ext_filter.sv */
// digital filter for the conditioned external trigger
// assumes sampleTick pulses at the chosen sampling rate, kernel domain
`timescale 1ns/1ps
`default_nettype none
module tsc_ext_filter
	import tsc_pkg::*;
#(
	parameter int CNT_W = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sampleTick,
	input wire logic sigIn,
	input wire logic [CNT_W-1:0] needCount,
	output logic sigOut
);

	initial begin
		if (CNT_W < 4) $error("tsc_ext_filter: CNT_W must hold a count of 8");
	end

	logic [CNT_W-1:0] agree_reg;
	logic out_reg;

	// ----------------------------------------
	// event counter: N samples in a row at the new level
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			agree_reg <= '0;
			out_reg <= 1'b0;
		end else if (sampleTick) begin
			if (sigIn == out_reg) begin
				agree_reg <= '0;
			end else if (agree_reg + 1'b1 >= needCount) begin
				out_reg <= sigIn;
				agree_reg <= '0;
			end else begin
				agree_reg <= agree_reg + 1'b1;
			end
		end
	end

	assign sigOut = out_reg;

endmodule
`default_nettype wire

/* design/tsc_slave_ctrl.sv */
// slave-mode and trigger-input controller of the advanced timer
// assumes an Avalon-MM master; counter core consumes cntCtrl and reports overflow-free
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tsc_slave_ctrl
	import tsc_pkg::*;
#(
	parameter int DTS_DIV_MAX = 32,
	parameter int SYNC_DELAY = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_trigger_pin,
	input wire logic filter_sample_clock,
	input wire logic internal_trigger_zero,
	input wire logic ch1_edge_detect,
	input wire logic ch1_filtered_input,
	input wire logic ch2_filtered_input,
	input wire logic counter_run_sw,
	input wire logic counter_run_clear,
	output logic counter_run,
	output logic trigger_input,
	output logic filtered_ext_trigger,
	output logic [4:0] trigger_select,
	output tsc_cnt_ctrl_t cntCtrl
);

	initial begin
		if (DTS_DIV_MAX != 32) $error("tsc_slave_ctrl: DTS_DIV_MAX must be 32");
		if (SYNC_DELAY < 1 || SYNC_DELAY > 8) $error("tsc_slave_ctrl: SYNC_DELAY out of range");
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [31:0] smc_reg;
	logic trigFlag_reg;
	logic ackd_reg;
	logic [31:0] rdata_reg;
	logic busReq;
	logic hitSmc;
	logic hitStat;
	logic trigFlagSet;
	logic [31:0] beMask;
	logic busDone;

	assign busReq = (avs_read || avs_write) && !ackd_reg;
	assign avs_waitrequest = busReq;
	// second cycle of a held request: waitrequest low, transfer completes here
	assign busDone = (avs_read || avs_write) && ackd_reg;
	assign hitSmc = avs_address == OFF_SLAVE_MODE_CONTROL;
	assign hitStat = avs_address == OFF_SLAVE_STATUS;
	assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ackd_reg <= 1'b0;
		end else begin
			ackd_reg <= busReq;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			smc_reg <= SMC_RESET;
		end else if (busDone && avs_write && hitSmc) begin
			smc_reg <= (smc_reg & ~(beMask & SMC_WRITE_MASK)) | (avs_writedata & beMask & SMC_WRITE_MASK);
		end
	end

	logic [31:0] statusWord;
	always_comb begin
		statusWord = '0;
		statusWord[POS_TRIG_FLAG] = trigFlag_reg;
		statusWord[POS_RUN] = counter_run;
		statusWord[POS_FILT_OUT] = filtered_ext_trigger;
		statusWord[POS_TRIG_IN] = trigger_input;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else if (busReq && avs_read) begin
			rdata_reg <= hitSmc ? smc_reg : (hitStat ? statusWord : 32'h00000000);
		end
	end
	assign avs_readdata = rdata_reg;

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	logic polInv;
	logic clkMode2;
	logic [1:0] pscSel;
	logic [3:0] fltSel;
	logic msmOn;
	logic [3:0] smSel;

	assign polInv = smc_reg[POS_POL];
	assign clkMode2 = smc_reg[POS_ECE];
	assign pscSel = smc_reg[POS_PSC_HI:POS_PSC_LO];
	assign fltSel = smc_reg[POS_FLT_HI:POS_FLT_LO];
	assign msmOn = smc_reg[POS_MSM];
	assign trigger_select = {smc_reg[POS_TSU_HI:POS_TSU_LO], smc_reg[POS_TSL_HI:POS_TSL_LO]};
	assign smSel = {smc_reg[POS_SMS3], smc_reg[POS_SMSL_HI:POS_SMSL_LO]};

	// ----------------------------------------
	// external trigger conditioning
	// ----------------------------------------
	logic polTrig;
	logic polTrig_reg;
	logic [2:0] psc_reg;
	logic prescaled_ext_trigger;

	assign polTrig = ext_trigger_pin ^ polInv;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			polTrig_reg <= 1'b0;
			psc_reg <= '0;
		end else begin
			polTrig_reg <= polTrig;
			if (polTrig && !polTrig_reg) begin
				psc_reg <= psc_reg + 3'h1;
			end
		end
	end

	always_comb begin
		unique case (pscSel)
			2'b00: prescaled_ext_trigger = polTrig;
			2'b01: prescaled_ext_trigger = psc_reg[0];
			2'b10: prescaled_ext_trigger = psc_reg[1];
			2'b11: prescaled_ext_trigger = psc_reg[2];
		endcase
	end

	// sampling rate and N per filter code
	logic [5:0] dtsDiv;
	logic [3:0] needN;
	logic [4:0] dtsCnt_reg;
	logic dtsPrev_reg;
	logic dtsTick;
	logic sampleTick;

	always_comb begin
		dtsDiv = 6'h01;
		needN = 4'h1;
		unique case (fltSel)
			4'h0: begin dtsDiv = 6'h01; needN = 4'h1; end
			4'h1: begin dtsDiv = 6'h01; needN = 4'h2; end
			4'h2: begin dtsDiv = 6'h01; needN = 4'h4; end
			4'h3: begin dtsDiv = 6'h01; needN = 4'h8; end
			4'h4: begin dtsDiv = 6'h02; needN = 4'h6; end
			4'h5: begin dtsDiv = 6'h02; needN = 4'h8; end
			4'h6: begin dtsDiv = 6'h04; needN = 4'h6; end
			4'h7: begin dtsDiv = 6'h04; needN = 4'h8; end
			4'h8: begin dtsDiv = 6'h08; needN = 4'h6; end
			4'h9: begin dtsDiv = 6'h08; needN = 4'h8; end
			4'hA: begin dtsDiv = 6'h10; needN = 4'h5; end
			4'hB: begin dtsDiv = 6'h10; needN = 4'h6; end
			4'hC: begin dtsDiv = 6'h10; needN = 4'h8; end
			4'hD: begin dtsDiv = 6'h20; needN = 4'h5; end
			4'hE: begin dtsDiv = 6'h20; needN = 4'h6; end
			4'hF: begin dtsDiv = 6'h20; needN = 4'h8; end
		endcase
	end

	// sample ticks: every kernel cycle for filter codes 1 to 3, else filter clock edges divided down
	assign dtsTick = filter_sample_clock && !dtsPrev_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dtsPrev_reg <= 1'b0;
			dtsCnt_reg <= '0;
		end else begin
			dtsPrev_reg <= filter_sample_clock;
			if (dtsTick) begin
				dtsCnt_reg <= ({1'b0, dtsCnt_reg} + 6'h01 >= dtsDiv) ? 5'h00 : dtsCnt_reg + 5'h01;
			end
		end
	end
	assign sampleTick = (fltSel != FLT_NONE && fltSel <= FLT_KCLK_MAX) ? 1'b1 :
		(dtsTick && ({1'b0, dtsCnt_reg} + 6'h01 >= dtsDiv));

	tsc_ext_filter #(
		.CNT_W(4)
	) u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.sampleTick(sampleTick),
		.sigIn(prescaled_ext_trigger),
		.needCount(needN),
		.sigOut(filtered_ext_trigger)
	);

	// ----------------------------------------
	// trigger select and master/slave delay
	// ----------------------------------------
	logic trigRaw;
	logic [7:0] msmPipe_reg;
	logic trigPrev_reg;
	logic trigRise;
	logic trigFall;

	always_comb begin
		unique case (trigger_select)
			TS_INTERNAL_TRIGGER_ZERO: trigRaw = internal_trigger_zero;
			TS_CH1_EDGE: trigRaw = ch1_edge_detect;
			TS_CH1_FILT: trigRaw = ch1_filtered_input;
			TS_CH2_FILT: trigRaw = ch2_filtered_input;
			TS_EXT_FILT: trigRaw = filtered_ext_trigger;
			default: trigRaw = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			msmPipe_reg <= '0;
		end else begin
			msmPipe_reg <= {msmPipe_reg[6:0], trigRaw};
		end
	end
	assign trigger_input = msmOn ? msmPipe_reg[SYNC_DELAY-1] : trigRaw;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trigPrev_reg <= 1'b0;
		end else begin
			trigPrev_reg <= trigger_input;
		end
	end
	assign trigRise = trigger_input && !trigPrev_reg;
	assign trigFall = !trigger_input && trigPrev_reg;

	// external clock mode 2 edge detector
	logic ext2Prev_reg;
	logic ext2Rise;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext2Prev_reg <= 1'b0;
		end else begin
			ext2Prev_reg <= filtered_ext_trigger;
		end
	end
	assign ext2Rise = filtered_ext_trigger && !ext2Prev_reg;

	// ----------------------------------------
	// encoder inputs
	// ----------------------------------------
	logic ch1Prev_reg;
	logic ch2Prev_reg;
	logic ch1Edge;
	logic ch2Edge;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ch1Prev_reg <= 1'b0;
			ch2Prev_reg <= 1'b0;
		end else begin
			ch1Prev_reg <= ch1_filtered_input;
			ch2Prev_reg <= ch2_filtered_input;
		end
	end
	assign ch1Edge = ch1_filtered_input ^ ch1Prev_reg;
	assign ch2Edge = ch2_filtered_input ^ ch2Prev_reg;

	// ----------------------------------------
	// slave mode actions
	// ----------------------------------------
	logic run_reg;
	logic hwStart;
	logic gateOpen;
	logic gatePrev_reg;
	logic clkSrcTick;
	tsc_cnt_ctrl_t ctrl_next;
	tsc_cnt_ctrl_t ctrl_reg;

	assign hwStart = trigRise && (smSel == SM_TRIGGER || smSel == SM_COMBINED);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_reg <= 1'b0;
		end else if (hwStart) begin
			run_reg <= 1'b1;
		end else if (counter_run_clear) begin
			run_reg <= 1'b0;
		end else if (counter_run_sw) begin
			run_reg <= 1'b1;
		end
	end
	assign counter_run = run_reg;

	// base clock: mode 2 edges, else the internal clock
	assign clkSrcTick = clkMode2 ? ext2Rise : 1'b1;
	assign gateOpen = run_reg && trigger_input;

	always_comb begin
		ctrl_next = '0;
		unique case (smSel)
			SM_ENC1: begin
				ctrl_next.countTick = run_reg && ch1Edge;
				ctrl_next.countDown = ch1_filtered_input == ch2_filtered_input;
			end
			SM_ENC2: begin
				ctrl_next.countTick = run_reg && ch2Edge;
				ctrl_next.countDown = ch1_filtered_input != ch2_filtered_input;
			end
			SM_ENC3: begin
				ctrl_next.countTick = run_reg && (ch1Edge || ch2Edge);
				ctrl_next.countDown = ch1Edge ? (ch1_filtered_input == ch2_filtered_input) :
					(ch1_filtered_input != ch2_filtered_input);
			end
			SM_RESET: begin
				ctrl_next.countTick = run_reg && clkSrcTick;
				ctrl_next.counterReinit = trigRise;
				ctrl_next.updateEvent = trigRise;
			end
			SM_GATED: begin
				ctrl_next.countTick = gateOpen && clkSrcTick;
			end
			SM_TRIGGER: begin
				ctrl_next.countTick = run_reg && clkSrcTick;
				ctrl_next.counterStart = trigRise;
			end
			SM_EXTCLK1: begin
				ctrl_next.countTick = run_reg && trigRise;
			end
			SM_COMBINED: begin
				ctrl_next.countTick = run_reg && clkSrcTick;
				ctrl_next.counterReinit = trigRise;
				ctrl_next.updateEvent = trigRise;
				ctrl_next.counterStart = trigRise;
			end
			default: begin
				ctrl_next.countTick = run_reg && clkSrcTick;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end
	assign cntCtrl = ctrl_reg;

	// ----------------------------------------
	// trigger flag, set wins over clear
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gatePrev_reg <= 1'b0;
		end else begin
			gatePrev_reg <= gateOpen;
		end
	end

	always_comb begin
		if (smSel == SM_OFF || smSel > SM_COMBINED) begin
			trigFlagSet = 1'b0;
		end else if (smSel == SM_GATED) begin
			trigFlagSet = gateOpen != gatePrev_reg;
		end else begin
			trigFlagSet = trigRise;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trigFlag_reg <= 1'b0;
		end else if (trigFlagSet) begin
			trigFlag_reg <= 1'b1;
		end else if (busDone && avs_write && hitStat && avs_byteenable[0] && !avs_writedata[POS_TRIG_FLAG]) begin
			trigFlag_reg <= 1'b0;
		end
	end

	// unused for now: trigFall kept for gated-stop observation
	logic unusedFall;
	assign unusedFall = trigFall;

endmodule
`default_nettype wire

/* sim/tsc_peer_model.sv */
// peer timer trigger and encoder or external trigger source for the slave controller
// assumes the bench sets the control inputs just after rising edges
`timescale 1ns/1ps
`default_nettype none
module tsc_peer_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic encRun,
	input wire logic encRev,
	input wire logic extRun,
	input wire logic extLevel,
	input wire logic peerLevel,
	output logic peerTrig,
	output logic encA,
	output logic encB,
	output logic extPin
);
	// ----------------------------------------
	// quadrature and external clock
	// ----------------------------------------
	logic [1:0] phase_reg;
	logic [1:0] div_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_reg <= 2'h0;
			div_reg <= 2'h0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (encRun && div_reg == 2'h3) begin
				phase_reg <= encRev ? phase_reg - 2'h1 : phase_reg + 2'h1;
			end
		end
	end
	assign encA = phase_reg[1];
	assign encB = phase_reg[1] ^ phase_reg[0];
	// toggle every 4 cycles: an eighth of the kernel clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			extPin <= 1'b0;
		end else begin
			extPin <= extRun ? (extPin ^ (div_reg == 2'h3)) : extLevel;
		end
	end
	assign peerTrig = peerLevel;
endmodule
`default_nettype wire

/* sim/tsc_slave_ctrl_assertions.sv */
// assertion checker for the timer slave/trigger controller
// assumes it is bound to tsc_slave_ctrl and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module tsc_slave_ctrl_checker
	import tsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic internal_trigger_zero,
	input wire logic ch2_filtered_input,
	input wire logic counter_run,
	input wire logic trigger_input,
	input wire logic [4:0] trigger_select,
	input wire tsc_cnt_ctrl_t cntCtrl
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// master/slave bit as last written; routing checks hold only without the delay
	logic msmSeen_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			msmSeen_reg <= 1'b0;
		end else if (avs_write && !avs_waitrequest && avs_address == OFF_SLAVE_MODE_CONTROL && avs_byteenable[0]) begin
			msmSeen_reg <= avs_writedata[POS_MSM];
		end
	end

	property p_wait_first;
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("bus wait cycle wrong");
	property p_rsvd_zero;
		avs_read && !avs_waitrequest && avs_address == OFF_SLAVE_MODE_CONTROL |-> (avs_readdata & ~SMC_WRITE_MASK) == 0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");
	property p_ts_split;
		avs_write && !avs_waitrequest && avs_address == OFF_SLAVE_MODE_CONTROL && avs_byteenable == 4'hF
			|=> trigger_select == {$past(avs_writedata[21:20]), $past(avs_writedata[6:4])};
	endproperty
	a_ts_split: assert property (p_ts_split) else $error("trigger select field misplaced");
	property p_route_internal_trigger_zero;
		trigger_select == TS_INTERNAL_TRIGGER_ZERO && !msmSeen_reg |-> trigger_input == internal_trigger_zero;
	endproperty
	a_route_internal_trigger_zero: assert property (p_route_internal_trigger_zero) else $error("peer trigger not routed");
	property p_route_ch2;
		trigger_select == TS_CH2_FILT && !msmSeen_reg |-> trigger_input == ch2_filtered_input;
	endproperty
	a_route_ch2: assert property (p_route_ch2) else $error("channel 2 not routed");
	property p_rsvd_ts;
		trigger_select inside {5'h01, 5'h02, 5'h03} |-> !trigger_input;
	endproperty
	a_rsvd_ts: assert property (p_rsvd_ts) else $error("reserved source drives trigger");
	property p_reinit_update;
		cntCtrl.counterReinit |-> cntCtrl.updateEvent;
	endproperty
	a_reinit_update: assert property (p_reinit_update) else $error("reinit without update");
	property p_start_run;
		cntCtrl.counterStart |-> ##[0:1] counter_run;
	endproperty
	a_start_run: assert property (p_start_run) else $error("start did not set run");
	property p_tick_run;
		cntCtrl.countTick |-> counter_run || $past(counter_run) || cntCtrl.counterStart;
	endproperty
	a_tick_run: assert property (p_tick_run) else $error("tick while stopped");
	property p_update_pulse;
		cntCtrl.updateEvent |=> !cntCtrl.updateEvent;
	endproperty
	a_update_pulse: assert property (p_update_pulse) else $error("update longer than a cycle");
endmodule
bind tsc_slave_ctrl tsc_slave_ctrl_checker u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .internal_trigger_zero(internal_trigger_zero),
	.ch2_filtered_input(ch2_filtered_input), .counter_run(counter_run), .trigger_input(trigger_input),
	.trigger_select(trigger_select), .cntCtrl(cntCtrl));
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the timer slave/trigger controller
// assumes the peer model on the trigger side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb
	import tsc_pkg::*;
;
	localparam int SYNC = 2;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avsAddr = 4'h0;
	logic [3:0] avsBe = 4'hF;
	logic avsRd = 1'b0;
	logic avsWr = 1'b0;
	logic [31:0] avsWd = 32'h0;
	logic fsClk = 1'b0;
	logic ch1EdgeDet = 1'b0;
	logic runSw = 1'b0;
	logic runClr = 1'b0;
	logic encRun = 1'b0;
	logic encRev = 1'b0;
	logic extRun = 1'b0;
	logic extLevel = 1'b0;
	logic peerLevel = 1'b0;
	logic [31:0] avsRdData, q;
	logic avsWait, counterRun, trigIn, filtExt, peerTrig, encA, encB, extPin;
	logic [4:0] trigSel;
	tsc_cnt_ctrl_t cnt;
	int failures = 0;
	int comparisons = 0;
	int ticks, ups, downs, reinits, updates, starts, reinitAt;
	int cyc = 0;

	always #5 clk = ~clk;
	always @(posedge clk) fsClk <= ~fsClk;

	tsc_slave_ctrl #(.SYNC_DELAY(SYNC)) DUT (.clk(clk), .rst_n(rst_n), .avs_address(avsAddr), .avs_read(avsRd),
		.avs_write(avsWr), .avs_writedata(avsWd), .avs_byteenable(avsBe), .avs_readdata(avsRdData),
		.avs_waitrequest(avsWait), .ext_trigger_pin(extPin), .filter_sample_clock(fsClk),
		.internal_trigger_zero(peerTrig), .ch1_edge_detect(ch1EdgeDet), .ch1_filtered_input(encA),
		.ch2_filtered_input(encB), .counter_run_sw(runSw), .counter_run_clear(runClr), .counter_run(counterRun),
		.trigger_input(trigIn), .filtered_ext_trigger(filtExt), .trigger_select(trigSel), .cntCtrl(cnt));
	tsc_peer_model peer (.clk(clk), .rst_n(rst_n), .encRun(encRun), .encRev(encRev), .extRun(extRun),
		.extLevel(extLevel), .peerLevel(peerLevel), .peerTrig(peerTrig), .encA(encA), .encB(encB), .extPin(extPin));

	// ----------------------------------------
	// event counting and helpers
	// ----------------------------------------
	// counted on the falling edge, where the registered actions have settled
	always @(negedge clk) begin
		cyc++;
		ticks += int'(cnt.countTick === 1'b1);
		ups += int'(cnt.countTick === 1'b1 && cnt.countDown === 1'b0);
		downs += int'(cnt.countTick === 1'b1 && cnt.countDown === 1'b1);
		updates += int'(cnt.updateEvent === 1'b1);
		starts += int'(cnt.counterStart === 1'b1);
		if (cnt.counterReinit === 1'b1) begin
			reinits++;
			reinitAt = cyc;
		end
	end
	task automatic zero;
		ticks = 0;
		ups = 0;
		downs = 0;
		reinits = 0;
		updates = 0;
		starts = 0;
	endtask
	function automatic logic [31:0] smc(input logic [3:0] sm, input logic [4:0] ts, input logic [3:0] flt,
		input logic [1:0] psc, input logic ece, input logic pol);
		return {10'h000, ts[4:3], 3'h0, sm[3], pol, ece, psc, flt, 1'b0, ts[2:0], 1'b0, sm[2:0]};
	endfunction
	task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmpCnt(input int g, input int e, input int tol);
		comparisons++;
		if (g > e + tol || g < e - tol) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avsAddr <= a;
		avsWd <= d;
		avsWr <= w;
		avsRd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (avsWait !== 1'b0 && n < 50);
		q = avsRdData;
		avsWr <= 1'b0;
		avsRd <= 1'b0;
		failures += int'(n >= 50);
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [3:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic setRun(input logic on);
		runSw <= on;
		runClr <= !on;
		@(posedge clk);
		runSw <= 1'b0;
		runClr <= 1'b0;
		@(posedge clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(4'h8);
		cmp32(q, SMC_RESET);
		wr(4'h8, 32'hFFFFFFFF);
		rd(4'h8);
		cmp32(q, SMC_WRITE_MASK);
		avsBe <= 4'h1;
		wr(4'h8, 32'h00000000);
		avsBe <= 4'hF;
		cmp32({27'h0, trigSel}, 32'h00000018);
		wr(4'h4, 32'hFFFFFFFF);
		rd(4'h4);
		cmp32(q, 32'h00000000);
		rd(4'h8);
		cmp32(q, SMC_WRITE_MASK & 32'hFFFFFF00);
	endtask
	task automatic t_route;
		logic [4:0] ts [6] = '{TS_INTERNAL_TRIGGER_ZERO, TS_CH1_EDGE, TS_CH1_FILT, TS_CH2_FILT, TS_EXT_FILT, 5'h01};
		logic [5:0] src;
		encRun <= 1'b1;
		extRun <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			wr(4'h8, smc(SM_OFF, ts[i], FLT_NONE, 2'h0, 1'b0, 1'b0));
			for (int n = 0; n < 24; n++) begin
				peerLevel <= n[2];
				ch1EdgeDet <= n[0];
				@(posedge clk);
				src = {1'b0, filtExt, encB, encA, ch1EdgeDet, peerTrig};
				cmp32({31'h0, trigIn}, {31'h0, src[i]});
			end
		end
		encRun <= 1'b0;
		extRun <= 1'b0;
		peerLevel <= 1'b0;
	endtask
	task automatic t_filter;
		for (int p = 0; p < 2; p++) begin
			extLevel <= 1'b0;
			wr(4'h8, smc(SM_OFF, TS_EXT_FILT, 4'h3, 2'h0, 1'b0, p[0]));
			repeat (20) @(posedge clk);
			cmp32({31'h0, filtExt}, 32'(p));
			extLevel <= 1'b1;
			repeat (5) @(posedge clk);
			extLevel <= 1'b0;
			repeat (20) @(posedge clk);
			cmp32({31'h0, filtExt}, 32'(p));
			extLevel <= 1'b1;
			repeat (25) @(posedge clk);
			cmp32({31'h0, filtExt}, 32'(1 - p));
		end
	endtask
	task automatic t_extclk;
		extRun <= 1'b1;
		setRun(1'b1);
		for (int i = 0; i < 5; i++) begin
			wr(4'h8, i < 4 ? smc(SM_OFF, TS_INTERNAL_TRIGGER_ZERO, FLT_NONE, 2'(i), 1'b1, 1'b0)
				: smc(SM_EXTCLK1, TS_EXT_FILT, FLT_NONE, 2'h1, 1'b0, 1'b0));
			repeat (16) @(posedge clk);
			zero();
			repeat (256) @(posedge clk);
			cmpCnt(ticks, i < 4 ? 32 >> i : 16, 1);
		end
		extRun <= 1'b0;
	endtask
	task automatic t_internal;
		logic [3:0] md [2] = '{SM_OFF, 4'h9};
		for (int i = 0; i < 2; i++) begin
			wr(4'h8, smc(md[i], TS_INTERNAL_TRIGGER_ZERO, FLT_NONE, 2'h0, 1'b0, 1'b0));
			setRun(1'b1);
			zero();
			repeat (20) @(posedge clk);
			cmpCnt(ticks, 20, 1);
			setRun(1'b0);
			zero();
			repeat (10) @(posedge clk);
			cmpCnt(ticks, 0, 0);
		end
	endtask
	task automatic t_modes;
		logic [3:0] md [4] = '{SM_RESET, SM_TRIGGER, SM_COMBINED, SM_RESET};
		int lat [4];
		int t0;
		for (int i = 0; i < 4; i++) begin
			setRun(1'b0);
			wr(4'h8, smc(md[i], TS_INTERNAL_TRIGGER_ZERO, FLT_NONE, 2'h0, 1'b0, 1'b0) | (i == 3 ? 32'h00000080 : 32'h00000000));
			wr(4'hC, 32'h00000000);
			zero();
			t0 = cyc;
			peerLevel <= 1'b1;
			repeat (12) @(posedge clk);
			peerLevel <= 1'b0;
			repeat (4) @(posedge clk);
			lat[i] = reinitAt - t0;
			cmpCnt(reinits, int'(md[i] != SM_TRIGGER), 0);
			cmpCnt(updates, int'(md[i] != SM_TRIGGER), 0);
			cmpCnt(starts, int'(md[i] != SM_RESET), 0);
			cmp32({31'h0, counterRun}, {31'h0, md[i] != SM_RESET});
			rd(4'hC);
			cmp32(q & 32'h00000001, 32'h00000001);
		end
		cmpCnt(lat[3], lat[0] + SYNC, 0);
	endtask
	task automatic t_gated;
		wr(4'h8, smc(SM_GATED, TS_INTERNAL_TRIGGER_ZERO, FLT_NONE, 2'h0, 1'b0, 1'b0));
		setRun(1'b1);
		wr(4'hC, 32'h00000000);
		zero();
		peerLevel <= 1'b1;
		repeat (30) @(posedge clk);
		peerLevel <= 1'b0;
		repeat (20) @(posedge clk);
		cmpCnt(ticks, 30, 2);
		cmpCnt(reinits, 0, 0);
		rd(4'hC);
		cmp32(q & 32'h00000003, 32'h00000003);
	endtask
	task automatic t_encoder;
		logic dirFwd;
		for (int m = 1; m < 4; m++) begin
			setRun(1'b0);
			wr(4'h8, smc(4'(m), TS_INTERNAL_TRIGGER_ZERO, FLT_NONE, 2'h0, 1'b0, 1'b0));
			setRun(1'b1);
			encRun <= 1'b1;
			for (int r = 0; r < 2; r++) begin
				encRev <= r[0];
				repeat (8) @(posedge clk);
				zero();
				repeat (64) @(posedge clk);
				cmpCnt(ticks, m == 3 ? 16 : 8, 1);
				cmpCnt(ups * downs, 0, 0);
				if (r == 0) dirFwd = downs > ups;
				else cmpCnt(int'(downs > ups), int'(!dirFwd), 0);
			end
			encRun <= 1'b0;
		end
	endtask

	task automatic print_verdict;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_route();
		t_filter();
		t_extclk();
		t_internal();
		t_modes();
		t_gated();
		t_encoder();
		print_verdict();
	end
	initial begin
		repeat (10000) @(posedge clk);
		failures++;
		print_verdict();
	end
endmodule
`default_nettype wire
